// ===== logic/acc_defs.svh
// Register indices, field positions, reset values and timing figures of calibration control
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// Register indices; the byte address is four times the index
`define ACC_IDX_CAL_ENABLE 8'h61
`define ACC_IDX_CFG_ZERO 8'h62
`define ACC_IDX_CFG_ONE 8'h65
`define ACC_IDX_AVERAGING 8'h68
`define ACC_IDX_PROGRESS 8'h6a
`define ACC_IDX_PIN_SETUP 8'h6b
`define ACC_IDX_SOFT_TRIG 8'h6c
`define ACC_IDX_IRQ_STATUS 8'h70
`define ACC_IDX_IRQ_MASK 8'h71

// Reset values
`define ACC_RST_CAL_ENABLE 8'h01
`define ACC_RST_CFG_ZERO 8'h01
`define ACC_RST_CFG_ONE 8'h01
`define ACC_RST_AVERAGING 8'h61
`define ACC_RST_PIN_SETUP 8'h00
`define ACC_RST_SOFT_TRIG 8'h01
`define ACC_RST_IRQ_MASK 8'h00

// Field positions
`define ACC_BIT_CAL_ENABLE 0
`define ACC_BIT_FG_ENABLE 0
`define ACC_BIT_BG_ENABLE 1
`define ACC_BIT_OFFSET_REFERENCE_SELECT 2
`define ACC_OFFSET_AVERAGING_DEPTH_HI 6
`define ACC_OFFSET_AVERAGING_DEPTH_LO 4
`define ACC_LIN_AVG_HI 2
`define ACC_LIN_AVG_LO 0
`define ACC_STAT_CODE_HI 4
`define ACC_STAT_CODE_LO 2
`define ACC_BIT_STOPPED 1
`define ACC_BIT_FOREGROUND_COMPLETE_FLAG 0
`define ACC_STAT_SEL_HI 2
`define ACC_STAT_SEL_LO 1
`define ACC_BIT_TRIG_SRC 0
`define ACC_BIT_SOFT_TRIG 0

// Interrupt status bits
`define ACC_IRQ_FOREGROUND_COMPLETE_FLAG 0
`define ACC_IRQ_STOPPED 1
`define ACC_IRQ_ALARM 2
`define ACC_IRQ_TRIGGER 3
`define ACC_IRQ_BITS 4

// Writable-bit masks of the registers software may change
`define ACC_WMASK_CAL_ENABLE 8'hff
`define ACC_WMASK_CFG_ZERO 8'hff
`define ACC_WMASK_CFG_ONE 8'hff
`define ACC_WMASK_AVERAGING 8'hff
`define ACC_WMASK_PIN_SETUP 8'hff
`define ACC_WMASK_SOFT_TRIG 8'hff

// Bus latency: cycles that waitrequest stays high before the answer
`define ACC_BUS_WAIT_CYCLES 1

`endif

// ===== logic/acc_pkg.sv
// Types shared by the calibration control files
`default_nettype none
package acc_pkg;

  typedef enum logic [1:0]
  {
    ACC_SEL_FOREGROUND_COMPLETE_FLAG,
    ACC_SEL_STOPPED,
    ACC_SEL_ALARM,
    ACC_SEL_LOW
  } acc_status_sel_e;

  typedef enum
  {
    ACC_ST_HOLD,
    ACC_ST_FOREGROUND,
    ACC_ST_SETTLED
  } acc_seq_e;

  typedef logic [7:0] acc_byte_t;

endpackage
`default_nettype wire

// ===== logic/acc_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module acc_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("acc_sync: WIDTH must be at least 1");
    end
  endgenerate

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule // acc_sync
`default_nettype wire

// ===== logic/acc_avmm_slave.sv
// Avalon-MM slave front end: one wait cycle, then a one-cycle accept
`timescale 1ns/1ps
`default_nettype none
module acc_avmm_slave
#(
  parameter int ADDR_W = 10
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] reg_rdata,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);

  generate
    if (ADDR_W < 10)
    begin : g_bad_addr
      $error("acc_avmm_slave: ADDR_W must reach the highest register");
    end
  endgenerate

  logic ack_reg;
  logic [31:0] rdata_reg;
  wire req = avs_read | avs_write;
  wire capture = req & ~ack_reg;

  // Registers are 8 bits wide in lane 0; a write without lane 0 leaves them alone
  assign avs_waitrequest = req & ~ack_reg;
  assign reg_addr = avs_address;
  assign reg_wdata = avs_writedata[7:0];
  assign reg_wr = ack_reg & avs_write & avs_byteenable[0];
  assign reg_rd = ack_reg & avs_read;
  assign avs_readdata = rdata_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= capture;
      if (capture && avs_read)
      begin
        rdata_reg <= {24'h00_0000, reg_rdata};
      end
    end
  end

endmodule // acc_avmm_slave
`default_nettype wire

// ===== logic/acc_cal_ctrl.sv
// Calibration control: configuration registers, progress flags, status pin and trigger select
// Function
// - Reference bit zero targets mid-code offset
// - Reference bit one tracks spare converter output
// - Bits six to four set offset averaging
// - Bits two to zero set linearity averaging
// - Progress register read-only, code bits four-two
// - Stopped flag follows background halt and resume
// - Without background, stopped follows foreground finish
// - Foreground complete flag set after finish or skip
// - Selector drives status pin per value
// - Source zero uses software trigger bit
// - Source one uses synchronised trigger pin
// - Background runs only while enabled
// - Software trigger bit replaces trigger pin
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.svh"
module acc_cal_ctrl
#(
  parameter int ADDR_W = 10
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic calibration_trigger_pin,
  output logic calibration_status_pin,
  input wire logic engine_fg_finished,
  input wire logic engine_bg_halted,
  input wire logic [2:0] engine_status_code,
  input wire logic alarm,
  output logic calibration_run,
  output logic foreground_run,
  output logic background_run,
  output logic offset_reference_select,
  output logic [2:0] offset_averaging_depth,
  output logic [2:0] linearity_averaging_depth,
  output logic calibration_trigger
);

  generate
    if (ADDR_W < 10)
    begin : g_bad_addr
      $error("acc_cal_ctrl: ADDR_W must reach the highest register");
    end
  endgenerate

  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] bus_rdata;

  acc_avmm_slave #(.ADDR_W(ADDR_W)) u_bus
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(bus_rdata),
    .avs_waitrequest(avs_waitrequest),
    .reg_rdata(reg_rdata),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd)
  );

  assign avs_readdata = bus_rdata;

  logic trig_pin_sync;

  acc_sync #(.WIDTH(1)) u_trig_sync
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(calibration_trigger_pin),
    .sync_out(trig_pin_sync)
  );

  // Address decode; byte address is index times four
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  wire sel_cal_enable = hit(reg_addr, `ACC_IDX_CAL_ENABLE);
  wire sel_cfg_zero = hit(reg_addr, `ACC_IDX_CFG_ZERO);
  wire sel_cfg_one = hit(reg_addr, `ACC_IDX_CFG_ONE);
  wire sel_averaging = hit(reg_addr, `ACC_IDX_AVERAGING);
  wire sel_progress = hit(reg_addr, `ACC_IDX_PROGRESS);
  wire sel_pin_setup = hit(reg_addr, `ACC_IDX_PIN_SETUP);
  wire sel_soft_trig = hit(reg_addr, `ACC_IDX_SOFT_TRIG);
  wire sel_irq_status = hit(reg_addr, `ACC_IDX_IRQ_STATUS);
  wire sel_irq_mask = hit(reg_addr, `ACC_IDX_IRQ_MASK);

  logic [7:0] cal_enable_reg;
  logic [7:0] cfg_zero_reg;
  logic [7:0] cfg_one_reg;
  logic [7:0] averaging_reg;
  logic [7:0] pin_setup_reg;
  logic [7:0] soft_trig_reg;
  logic [`ACC_IRQ_BITS-1:0] irq_status_reg;
  logic [`ACC_IRQ_BITS-1:0] irq_mask_reg;

  // Reserved bits are stored as written, except irq mask bits 7 to 4; software keeps them at reset values
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cal_enable_reg <= `ACC_RST_CAL_ENABLE;
      cfg_zero_reg <= `ACC_RST_CFG_ZERO;
      cfg_one_reg <= `ACC_RST_CFG_ONE;
      averaging_reg <= `ACC_RST_AVERAGING;
      pin_setup_reg <= `ACC_RST_PIN_SETUP;
      soft_trig_reg <= `ACC_RST_SOFT_TRIG;
      irq_mask_reg <= `ACC_IRQ_BITS'(`ACC_RST_IRQ_MASK);
    end
    else if (reg_wr)
    begin
      if (sel_cal_enable)
      begin
        cal_enable_reg <= reg_wdata & `ACC_WMASK_CAL_ENABLE;
      end
      if (sel_cfg_zero)
      begin
        cfg_zero_reg <= reg_wdata & `ACC_WMASK_CFG_ZERO;
      end
      if (sel_cfg_one)
      begin
        cfg_one_reg <= reg_wdata & `ACC_WMASK_CFG_ONE;
      end
      if (sel_averaging)
      begin
        averaging_reg <= reg_wdata & `ACC_WMASK_AVERAGING;
      end
      if (sel_pin_setup)
      begin
        pin_setup_reg <= reg_wdata & `ACC_WMASK_PIN_SETUP;
      end
      if (sel_soft_trig)
      begin
        soft_trig_reg <= reg_wdata & `ACC_WMASK_SOFT_TRIG;
      end
      if (sel_irq_mask)
      begin
        irq_mask_reg <= reg_wdata[`ACC_IRQ_BITS-1:0];
      end
    end
  end

  wire cal_en = cal_enable_reg[`ACC_BIT_CAL_ENABLE];
  wire fg_en = cfg_zero_reg[`ACC_BIT_FG_ENABLE];
  wire bg_en = cfg_zero_reg[`ACC_BIT_BG_ENABLE];

  // Foreground sequencer; clearing the calibration enable holds it in reset
  acc_pkg::acc_seq_e seq_reg;
  acc_pkg::acc_seq_e seq_next;
  logic foreground_complete_flag_reg;
  logic foreground_complete_flag_next;

  always_comb
  begin
    seq_next = seq_reg;
    foreground_complete_flag_next = foreground_complete_flag_reg;
    case (seq_reg)
      acc_pkg::ACC_ST_HOLD:
      begin
        foreground_complete_flag_next = 1'b0;
        if (cal_en)
        begin
          // A skipped foreground counts as complete at once
          seq_next = fg_en ? acc_pkg::ACC_ST_FOREGROUND : acc_pkg::ACC_ST_SETTLED;
          foreground_complete_flag_next = ~fg_en;
        end
      end
      acc_pkg::ACC_ST_FOREGROUND:
      begin
        if (!cal_en)
        begin
          seq_next = acc_pkg::ACC_ST_HOLD;
        end
        else if (engine_fg_finished)
        begin
          seq_next = acc_pkg::ACC_ST_SETTLED;
          foreground_complete_flag_next = 1'b1;
        end
      end
      acc_pkg::ACC_ST_SETTLED:
      begin
        if (!cal_en)
        begin
          seq_next = acc_pkg::ACC_ST_HOLD;
          foreground_complete_flag_next = 1'b0;
        end
      end
      default:
      begin
        seq_next = acc_pkg::ACC_ST_HOLD;
        foreground_complete_flag_next = 1'b0;
      end
    endcase
  end

  // Background runs only after foreground settles and while enabled
  // Clearing the calibration enable stops background at once, not a cycle later
  wire bg_run = bg_en & cal_en & (seq_reg == acc_pkg::ACC_ST_SETTLED);

  // Halt follows the engine with background on, otherwise the foreground result
  wire stopped_now = bg_en ? (bg_run & engine_bg_halted) : foreground_complete_flag_reg;

  // Flags come from the sequencer and the engine halt, the code from the engine; no write to this register reaches them
  wire [7:0] progress_val = {3'b000, engine_status_code, stopped_now, foreground_complete_flag_reg};

  // Trigger source select
  wire trig_src_hw = pin_setup_reg[`ACC_BIT_TRIG_SRC];
  wire soft_trig = soft_trig_reg[`ACC_BIT_SOFT_TRIG];
  wire trig_sel = trig_src_hw ? trig_pin_sync : soft_trig;

  // Status pin selector
  acc_pkg::acc_status_sel_e stat_sel;
  assign stat_sel = acc_pkg::acc_status_sel_e'(pin_setup_reg[`ACC_STAT_SEL_HI:`ACC_STAT_SEL_LO]);
  logic stat_pin_next;

  always_comb
  begin
    case (stat_sel)
      acc_pkg::ACC_SEL_FOREGROUND_COMPLETE_FLAG: stat_pin_next = foreground_complete_flag_reg;
      acc_pkg::ACC_SEL_STOPPED: stat_pin_next = stopped_now;
      acc_pkg::ACC_SEL_ALARM: stat_pin_next = alarm;
      acc_pkg::ACC_SEL_LOW: stat_pin_next = 1'b0;
      default: stat_pin_next = 1'b0;
    endcase
  end

  // Interrupt events are rising edges of the flags, of the alarm input and of the chosen trigger
  logic foreground_complete_flag_d_reg;
  logic stopped_d_reg;
  logic alarm_d_reg;
  logic trig_d_reg;
  wire [`ACC_IRQ_BITS-1:0] irq_events = {trig_sel & ~trig_d_reg,
                                         alarm & ~alarm_d_reg,
                                         stopped_now & ~stopped_d_reg,
                                         foreground_complete_flag_reg & ~foreground_complete_flag_d_reg};

  // Read clears only the bits the master saw; a new event in that cycle wins
  wire [`ACC_IRQ_BITS-1:0] irq_clear = (reg_rd && sel_irq_status) ?
                                       bus_rdata[`ACC_IRQ_BITS-1:0] : '0;
  wire [`ACC_IRQ_BITS-1:0] irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;

  // Read mux; unmapped addresses read zero
  assign reg_rdata = sel_cal_enable ? cal_enable_reg :
                     sel_cfg_zero ? cfg_zero_reg :
                     sel_cfg_one ? cfg_one_reg :
                     sel_averaging ? averaging_reg :
                     sel_progress ? progress_val :
                     sel_pin_setup ? pin_setup_reg :
                     sel_soft_trig ? soft_trig_reg :
                     sel_irq_status ? 8'(irq_status_reg) :
                     sel_irq_mask ? 8'(irq_mask_reg) :
                     8'h00;

  logic stat_pin_reg;
  logic trig_reg;
  logic irq_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      seq_reg <= acc_pkg::ACC_ST_HOLD;
      foreground_complete_flag_reg <= 1'b0;
      foreground_complete_flag_d_reg <= 1'b0;
      stopped_d_reg <= 1'b0;
      alarm_d_reg <= 1'b0;
      // Matches the reset trigger (software bit high) so reset raises no false event
      trig_d_reg <= 1'b1;
      irq_status_reg <= '0;
      stat_pin_reg <= 1'b0;
      trig_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      seq_reg <= seq_next;
      foreground_complete_flag_reg <= foreground_complete_flag_next;
      foreground_complete_flag_d_reg <= foreground_complete_flag_reg;
      stopped_d_reg <= stopped_now;
      alarm_d_reg <= alarm;
      trig_d_reg <= trig_sel;
      irq_status_reg <= irq_status_next;
      stat_pin_reg <= stat_pin_next;
      trig_reg <= trig_sel;
      irq_reg <= |(irq_status_next & irq_mask_reg);
    end
  end

  // Engine controls come from register bits, except foreground and background run (sequencer) and the trigger (registered from the selected source)
  assign calibration_run = cal_en;
  assign foreground_run = (seq_reg == acc_pkg::ACC_ST_FOREGROUND);
  assign background_run = bg_run;
  // Zero means mid-code target; one means match the spare converter
  // Spare reference with background off is left to software to avoid
  assign offset_reference_select = cfg_one_reg[`ACC_BIT_OFFSET_REFERENCE_SELECT];
  assign offset_averaging_depth = averaging_reg[`ACC_OFFSET_AVERAGING_DEPTH_HI:`ACC_OFFSET_AVERAGING_DEPTH_LO];
  assign linearity_averaging_depth = averaging_reg[`ACC_LIN_AVG_HI:`ACC_LIN_AVG_LO];
  assign calibration_trigger = trig_reg;
  assign calibration_status_pin = stat_pin_reg;
  assign irq = irq_reg;

endmodule // acc_cal_ctrl
`default_nettype wire

// ===== tb/acc_cal_ctrl_props.sv
// Assertions on the calibration control top ports
`timescale 1ns/1ps
`default_nettype none
module acc_cal_ctrl_props
#(
  parameter int ADDR_W = 10
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic calibration_trigger_pin,
  input wire logic calibration_status_pin,
  input wire logic engine_fg_finished,
  input wire logic engine_bg_halted,
  input wire logic [2:0] engine_status_code,
  input wire logic alarm,
  input wire logic calibration_run,
  input wire logic foreground_run,
  input wire logic background_run,
  input wire logic offset_reference_select,
  input wire logic [2:0] offset_averaging_depth,
  input wire logic [2:0] linearity_averaging_depth,
  input wire logic calibration_trigger
);
  logic [1:0] sel_q;
  logic src_q;
  logic soft_q;
  logic [2:0] up_q;
  wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire pin_wr = wr_ok && avs_address == ADDR_W'(10'h1ac);
  wire soft_wr = wr_ok && avs_address == ADDR_W'(10'h1b0);
  // Pin relations wait until the trigger synchroniser has flushed after reset
  wire up = up_q == 3'h7;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sel_q <= 2'h0;
      src_q <= 1'b0;
      soft_q <= 1'b1;
      up_q <= 3'h0;
    end
    else
    begin
      up_q <= up ? up_q : up_q + 3'h1;
      sel_q <= pin_wr ? avs_writedata[2:1] : sel_q;
      src_q <= pin_wr ? avs_writedata[0] : src_q;
      soft_q <= soft_wr ? avs_writedata[0] : soft_q;
    end
  end
  sequence bus_req_s;
    $rose(avs_read || avs_write);
  endsequence
  sequence fg_end_s;
    foreground_run && engine_fg_finished;
  endsequence
  chk_bus_wait: assert property (bus_req_s |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  chk_avg_depth: assert property (wr_ok && avs_address == ADDR_W'(10'h1a0) |=>
    offset_averaging_depth == $past(avs_writedata[6:4])
    && linearity_averaging_depth == $past(avs_writedata[2:0]))
    else $error("averaging depth not taken from write");
  chk_ref_sel: assert property (wr_ok && avs_address == ADDR_W'(10'h194) |=>
    offset_reference_select == $past(avs_writedata[2]))
    else $error("offset reference not taken from write");
  chk_progress_read: assert property (avs_read && !avs_waitrequest
    && avs_address == ADDR_W'(10'h1a8) |-> avs_readdata[31:5] == 27'h0
    && avs_readdata[4:2] == $past(engine_status_code))
    else $error("progress read data wrong");
  chk_foreground_complete_flag: assert property (fg_end_s ##0 sel_q == 2'h0 |-> ##2 calibration_status_pin)
    else $error("foreground completion not shown on pin");
  chk_fg_leave: assert property (fg_end_s |=> !foreground_run)
    else $error("foreground still running after finish");
  chk_pin_alarm: assert property (up && $past(sel_q) == 2'h2
    |-> calibration_status_pin == $past(alarm))
    else $error("status pin does not follow alarm");
  chk_pin_low: assert property (up && $past(sel_q) == 2'h3 |-> !calibration_status_pin)
    else $error("status pin not held low");
  chk_pin_stop: assert property (up && $past(sel_q) == 2'h1 && $past(background_run)
    |-> calibration_status_pin == $past(engine_bg_halted))
    else $error("status pin does not follow stopped flag");
  chk_soft_trig: assert property (up && !$past(src_q)
    |-> calibration_trigger == $past(soft_q))
    else $error("trigger does not follow software bit");
  chk_pin_trig: assert property (up && $past(src_q)
    |-> calibration_trigger == $past(calibration_trigger_pin, 3))
    else $error("trigger does not follow trigger pin");
  chk_bg_gate: assert property (background_run |-> calibration_run && !foreground_run)
    else $error("background runs while not allowed");
endmodule // acc_cal_ctrl_props
bind acc_cal_ctrl acc_cal_ctrl_props #(.ADDR_W(ADDR_W)) u_props (.clk_sys, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq,
  .calibration_trigger_pin, .calibration_status_pin, .engine_fg_finished, .engine_bg_halted,
  .engine_status_code, .alarm, .calibration_run, .foreground_run, .background_run,
  .offset_reference_select, .offset_averaging_depth, .linearity_averaging_depth,
  .calibration_trigger);
`default_nettype wire

// ===== tb/acc_cal_ctrl_bench.sv
// Self-checking bench for calibration control against a register model
`timescale 1ns/1ps
`default_nettype none
module acc_cal_ctrl_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] avs_address = 10'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic calibration_trigger_pin = 1'b0;
  logic engine_fg_finished = 1'b0;
  logic engine_bg_halted = 1'b0;
  logic [2:0] engine_status_code = 3'h0;
  logic alarm = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, calibration_status_pin, calibration_run, foreground_run;
  logic background_run, offset_reference_select, calibration_trigger;
  logic [2:0] offset_averaging_depth;
  logic [2:0] linearity_averaging_depth;
  logic [31:0] q;
  logic [31:0] r;
  logic [7:0] mdl [int];
  int mismatches = 0;
  int compares = 0;
  int seed = 4793;

  acc_cal_ctrl #(.ADDR_W(10)) dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq,
    .calibration_trigger_pin, .calibration_status_pin, .engine_fg_finished, .engine_bg_halted,
    .engine_status_code, .alarm, .calibration_run, .foreground_run, .background_run,
    .offset_reference_select, .offset_averaging_depth, .linearity_averaging_depth,
    .calibration_trigger);

  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp_data(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_pin(input string what, input logic e, input logic g);
    cmp_data(what, {31'h0, e}, {31'h0, g});
  endtask

  // Waitrequest is sampled at each rising edge; the edge that sees it low accepts the request
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        mismatches++;
        report_and_stop;
      end
      @(posedge clk_sys);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (wr && be[0] && mdl.exists(a))
      mdl[a] = d;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0, 4'h1);
    cmp_data($sformatf("register %h", a), {24'h0, e}, q);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  initial
  begin
    mdl[32'h184] = 8'h01;
    mdl[32'h188] = 8'h01;
    mdl[32'h194] = 8'h01;
    mdl[32'h1a0] = 8'h61;
    mdl[32'h1ac] = 8'h00;
    mdl[32'h1b0] = 8'h01;
    mdl[32'h1c4] = 8'h00;
    r = $random(seed);
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    engine_status_code <= r[2:0];
    step(1);
    foreach (mdl[k]) rd(10'(k), mdl[k]);
    rd(10'h3fc, 8'h00);
    rd(10'h1a8, {3'h0, engine_status_code, 2'h0});
    rd(10'h1c0, 8'h00);
    cmp_pin("calibration run", 1'b1, calibration_run);
    cmp_pin("foreground run", 1'b1, foreground_run);
    $display("done: reset values");
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      wr(10'h194, 8'h01);
      wr(10'h1a0, {1'b0, r[6:4], 1'b0, r[2:0]});
      bus(1'b1, 10'h1a0, r[15:8] & 8'h77, 4'h0);
      wr(10'h1a8, r[23:16]);
      step(0);
      cmp_data("offset depth", 32'(r[6:4]), 32'(offset_averaging_depth));
      cmp_data("linearity depth", 32'(r[2:0]), 32'(linearity_averaging_depth));
      cmp_pin("offset reference", 1'b0, offset_reference_select);
      rd(10'h1a0, mdl[32'h1a0]);
    end
    $display("done: averaging writes");
    wr(10'h1c4, 8'h05);
    @(posedge clk_sys);
    engine_fg_finished <= 1'b1;
    @(posedge clk_sys);
    engine_fg_finished <= 1'b0;
    step(2);
    cmp_pin("irq", 1'b1, irq);
    cmp_pin("foreground run", 1'b0, foreground_run);
    rd(10'h1a8, {3'h0, engine_status_code, 2'h3});
    rd(10'h1c0, 8'h03);
    step(1);
    cmp_pin("irq", 1'b0, irq);
    @(posedge clk_sys);
    alarm <= 1'b1;
    step(1);
    cmp_pin("irq", 1'b1, irq);
    wr(10'h1c4, 8'h01);
    step(1);
    cmp_pin("irq", 1'b0, irq);
    rd(10'h1c0, 8'h04);
    $display("done: foreground and interrupts");
    for (int s = 0; s < 8; s++)
    begin
      @(posedge clk_sys);
      alarm <= s[2];
      wr(10'h1ac, {5'h0, s[1:0], 1'b0});
      step(2);
      cmp_pin("status pin", s[1:0] == 2'h3 ? 1'b0 : (s[1] ? s[2] : 1'b1), calibration_status_pin);
    end
    $display("done: status pin select");
    for (int t = 0; t < 8; t++)
    begin
      wr(10'h1ac, {7'h0, t[2]});
      wr(10'h1b0, {7'h0, t[0]});
      @(posedge clk_sys);
      calibration_trigger_pin <= t[1];
      step(4);
      cmp_pin("trigger", t[2] ? t[1] : t[0], calibration_trigger);
    end
    rd(10'h1c0, 8'h0c);
    $display("done: trigger source");
    wr(10'h1ac, 8'h02);
    wr(10'h188, 8'h03);
    step(2);
    cmp_pin("background run", 1'b1, background_run);
    wr(10'h194, 8'h05);
    step(0);
    cmp_pin("offset reference", 1'b1, offset_reference_select);
    @(posedge clk_sys);
    engine_bg_halted <= 1'b1;
    rd(10'h1a8, {3'h0, engine_status_code, 2'h3});
    step(1);
    cmp_pin("status pin", 1'b1, calibration_status_pin);
    @(posedge clk_sys);
    engine_bg_halted <= 1'b0;
    rd(10'h1a8, {3'h0, engine_status_code, 2'h1});
    wr(10'h184, 8'h00);
    step(1);
    cmp_pin("background run", 1'b0, background_run);
    cmp_pin("calibration run", 1'b0, calibration_run);
    rd(10'h1a8, {3'h0, engine_status_code, 2'h0});
    $display("done: background calibration");
    report_and_stop;
  end
endmodule // acc_cal_ctrl_bench
`default_nettype wire
